// ### logic/bieh_consts.svh
/*
 * Named offsets, field positions, codes and reset values of the bridge
 * interrupt and error handling block. Included by the top, the link model and the bench.
 */
`ifndef BIEH_CONSTS_SVH
`define BIEH_CONSTS_SVH
// register byte offsets
`define BIEH_OFF_CTRL 8'h00
`define BIEH_OFF_MSICTL 8'h04
`define BIEH_OFF_MSIADDR 8'h08
`define BIEH_OFF_MSIDATA 8'h0C
`define BIEH_OFF_DECODE 8'h10
`define BIEH_OFF_MASK 8'h14
`define BIEH_OFF_TIMEOUT 8'h18
`define BIEH_OFF_STATUS 8'h1C
// control register fields
`define BIEH_CTRL_RP 0
`define BIEH_CTRL_PIN_LO 1
`define BIEH_CTRL_PIN_HI 3
`define BIEH_CTRL_ERREN 4
`define BIEH_CTRL_WMASK 32'h0000_001F
`define BIEH_PIN_INTA 3'h1
// message control fields
`define BIEH_MSI_EN 0
`define BIEH_MMC_LO 1
`define BIEH_MMC_HI 3
`define BIEH_MME_LO 4
`define BIEH_MME_HI 6
`define BIEH_NUM_MSI_REQ 3'h5
// interrupt decode bit positions
`define BIEH_IRQ_MSI 0
`define BIEH_IRQ_SIB 1
`define BIEH_IRQ_SUC 2
`define BIEH_IRQ_SUR 3
`define BIEH_IRQ_SCT 4
`define BIEH_IRQ_SEP 5
`define BIEH_IRQ_SCA 6
`define BIEH_IRQ_MEP 7
// bus and completion codes
`define BIEH_BURST_INCR 2'h1
`define BIEH_CPL_SC 3'h0
`define BIEH_CPL_CA 3'h4
`define BIEH_RESP_OKAY 2'h0
`define BIEH_RESP_SLVERR 2'h2
// reset values
`define BIEH_TIMEOUT_RST 32'h0000_30D4
`define BIEH_ZERO32 32'h0000_0000
`endif

// ### logic/bieh_pkg.sv
/*
 * Types shared by the bridge interrupt and error handling block.
 * Assumes bieh_consts.svh is on the include path.
 */
package bieh_pkg;
	// slave bridge request descriptor
	typedef struct packed {
		logic valid;
		logic isRead;
		logic posted;
		logic [1:0] burst;
		logic [15:0] reqId;
		logic [7:0] tag;
	} bieh_sreq_t;
	// received completion header
	typedef struct packed {
		logic valid;
		logic [15:0] reqId;
		logic [7:0] tag;
		logic [2:0] status;
		logic poison;
	} bieh_cpl_t;
	// answer to the slave bridge request
	typedef struct packed {
		logic valid;
		logic isRead;
		logic [1:0] resp;
	} bieh_sresp_t;
	// outgoing message write
	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		logic [31:0] data;
	} bieh_msi_t;
	typedef logic [7:0] bieh_irqvec_t;
	typedef enum logic [1:0] {
		BIEH_IDLE = 2'h1,
		BIEH_WAIT = 2'h2
	} bieh_state_t;
endpackage : bieh_pkg

// ### logic/bieh_top.sv
/*
 * Interrupt signalling and slave-side error handling of a memory-mapped to
 * serial-link bridge, with an AXI4-Lite register slave.
 * Assumes every input is synchronous to sys_clk, and one slave request at
 * a time is outstanding.
 */
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
// Overview of operation
// - local interrupt output asserts only for unmasked decode bits
// - message-received bit is set only in root port mode
// - with MSI enabled, request rising edge sends one MSI write
// - MSI address and data come from software-programmed config registers
// - request input honoured only in endpoint mode, ignored in root port
// - vector bits beyond allocated count are ignored
// - requested vector count log2 advertised in message control bits 3:1
// - allocated count output mirrors message control bits 6:4
// - legacy interrupts only with pin select INTA in endpoint mode
// - legacy with MSI off: rise sends assert, fall sends deassert
// - endpoint sends fatal error on malformed packet if reporting enabled
// - root port drops poisoned requests and sets master poison flag
// - non-incrementing bursts raise bad-burst strobe and answer SLVERR
// - non-posted incrementing requests await completion, checked for errors and absence
// - completion with wrong id or tag is dropped with strobe
// - unsupported or reserved status raises strobe and SLVERR
// - missing completion past timeout raises strobe and SLVERR
// - poisoned completion is discarded, strobe raised, SLVERR answered
// - completer abort status raises strobe and SLVERR
`timescale 1ns/1ps
`include "bieh_consts.svh"
module bieh_top (
	input wire logic sys_clk, // 250 MHz bridge clock
	input wire logic resetn, // synchronous reset, active low
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte enables
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic irqRequest, // MSI request or legacy level
	input wire logic [4:0] msiVectorNum, // MSI vector number
	input wire logic msiReceived, // MSI arrived (root port)
	input wire logic malformedTlp, // malformed packet seen
	input wire logic masterReqValid, // master bridge request packet
	input wire logic masterReqPoison, // its poison bit
	input wire bieh_pkg::bieh_sreq_t slaveReq, // slave bridge request
	output logic slaveReqReady, // slave request can be taken
	input wire bieh_pkg::bieh_cpl_t cplIn, // received completion
	output bieh_pkg::bieh_sresp_t slaveResp, // slave answer pulse
	output bieh_pkg::bieh_msi_t msiOut, // MSI write pulse
	output logic intaAssert, // assert message pulse
	output logic intaDeassert, // deassert message pulse
	output logic fatalErrMsg, // fatal error message pulse
	output logic masterReqKeep, // master request forwarded pulse
	output bieh_pkg::bieh_irqvec_t irqStrobe, // one-cycle event strobes
	output logic localIrq, // masked local interrupt
	output logic msiEnable, // MSI function enabled
	output logic [2:0] msiVectorWidth // allocated vector code
);
	import bieh_pkg::*;

	logic [31:0] ctrlReg;
	logic msiEn;
	logic [2:0] mme;
	logic [31:0] msiAddr;
	logic [31:0] msiData;
	bieh_irqvec_t decode;
	bieh_irqvec_t maskReg;
	logic [31:0] toLimit;
	logic [31:0] toCount;
	logic irqPrev;
	bieh_state_t state;
	logic [15:0] ostId;
	logic [7:0] ostTag;
	bieh_irqvec_t next_set;
	logic [31:0] rdMux;
	logic rdOk;
	logic wrOk;
	logic wrFire;
	logic rdFire;
	logic rootPort;
	logic endpoint;
	logic legacySel;
	logic irqRise;
	logic irqFall;
	wire [31:0] vecMask;
	logic reqTake;
	logic cplMatch;
	logic cplTimeout;

	// byte-lane merge of a write
	function automatic logic [31:0] wmerge(input logic [31:0] old,
		input logic [31:0] dat, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = dat[i*8 +: 8];
			end
		end
		return res;
	endfunction : wmerge

	// mode decode from control bits
	assign rootPort = ctrlReg[`BIEH_CTRL_RP];
	assign endpoint = !rootPort;
	assign legacySel = endpoint && (ctrlReg[`BIEH_CTRL_PIN_HI:`BIEH_CTRL_PIN_LO] == `BIEH_PIN_INTA);
	// input used as is, already on sys_clk
	assign irqRise = irqRequest && !irqPrev;
	assign irqFall = !irqRequest && irqPrev;
	assign msiEnable = msiEn;
	assign msiVectorWidth = mme;
	// vector bits kept per allocated count, none for reserved codes
	for (genvar i = 0; i < 32; i++) begin : g_vec_mask
		assign vecMask[i] = (mme <= `BIEH_NUM_MSI_REQ) && (i < int'(mme));
	end

	// register bus handshakes: address and data taken together
	assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_wready = s_axi_awready;
	assign wrFire = s_axi_awready;
	assign s_axi_arready = !s_axi_rvalid;
	assign rdFire = s_axi_arvalid && s_axi_arready;
	assign wrOk = (s_axi_awaddr == `BIEH_OFF_CTRL) || (s_axi_awaddr == `BIEH_OFF_MSICTL)
		|| (s_axi_awaddr == `BIEH_OFF_MSIADDR) || (s_axi_awaddr == `BIEH_OFF_MSIDATA)
		|| (s_axi_awaddr == `BIEH_OFF_DECODE) || (s_axi_awaddr == `BIEH_OFF_MASK)
		|| (s_axi_awaddr == `BIEH_OFF_TIMEOUT) || (s_axi_awaddr == `BIEH_OFF_STATUS);

	// read data selection
	always_comb begin
		rdOk = 1'b1;
		rdMux = `BIEH_ZERO32;
		case (s_axi_araddr)
			`BIEH_OFF_CTRL: rdMux = ctrlReg;
			`BIEH_OFF_MSICTL: rdMux = {25'h0, mme, `BIEH_NUM_MSI_REQ, msiEn};
			`BIEH_OFF_MSIADDR: rdMux = msiAddr;
			`BIEH_OFF_MSIDATA: rdMux = msiData;
			`BIEH_OFF_DECODE: rdMux = {24'h0, decode};
			`BIEH_OFF_MASK: rdMux = {24'h0, maskReg};
			`BIEH_OFF_TIMEOUT: rdMux = toLimit;
			`BIEH_OFF_STATUS: rdMux = {29'h0, irqPrev, state};
			default: rdOk = 1'b0;
		endcase
	end
	// write response channel
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `BIEH_RESP_OKAY;
		end else if (wrFire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wrOk ? `BIEH_RESP_OKAY : `BIEH_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
	// read data channel
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= `BIEH_ZERO32;
			s_axi_rresp <= `BIEH_RESP_OKAY;
		end else if (rdFire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdMux;
			s_axi_rresp <= rdOk ? `BIEH_RESP_OKAY : `BIEH_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			ctrlReg <= `BIEH_ZERO32;
			msiEn <= 1'b0;
			mme <= 3'h0;
			msiAddr <= `BIEH_ZERO32;
			msiData <= `BIEH_ZERO32;
			maskReg <= 8'h00;
			toLimit <= `BIEH_TIMEOUT_RST;
		end else if (wrFire) begin
			case (s_axi_awaddr)
				`BIEH_OFF_CTRL: ctrlReg <= wmerge(ctrlReg, s_axi_wdata, s_axi_wstrb) & `BIEH_CTRL_WMASK;
				`BIEH_OFF_MSICTL: begin
					if (s_axi_wstrb[0]) begin
						msiEn <= s_axi_wdata[`BIEH_MSI_EN];
						mme <= s_axi_wdata[`BIEH_MME_HI:`BIEH_MME_LO];
					end
				end
				`BIEH_OFF_MSIADDR: msiAddr <= wmerge(msiAddr, s_axi_wdata, s_axi_wstrb);
				`BIEH_OFF_MSIDATA: msiData <= wmerge(msiData, s_axi_wdata, s_axi_wstrb);
				`BIEH_OFF_MASK: begin
					if (s_axi_wstrb[0]) begin
						maskReg <= s_axi_wdata[7:0];
					end
				end
				`BIEH_OFF_TIMEOUT: toLimit <= wmerge(toLimit, s_axi_wdata, s_axi_wstrb);
				default: ;
			endcase
		end
	end
	// sticky decode, strobe wins over write-one-to-clear
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			decode <= 8'h00;
		end else if (wrFire && s_axi_awaddr == `BIEH_OFF_DECODE && s_axi_wstrb[0]) begin
			decode <= (decode & ~s_axi_wdata[7:0]) | irqStrobe;
		end else begin
			decode <= decode | irqStrobe;
		end
	end
	// only unmasked decode bits reach the local line
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			localIrq <= 1'b0;
		end else begin
			localIrq <= |(decode & maskReg);
		end
	end
	// request level history for edge detection
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			irqPrev <= 1'b0;
		end else begin
			irqPrev <= irqRequest;
		end
	end
	// MSI write on rising edge, endpoint only
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			msiOut <= '0;
		end else begin
			msiOut.valid <= endpoint && msiEn && irqRise;
			msiOut.addr <= msiAddr;
			// vector number merged into allocated low bits
			msiOut.data <= (msiData & ~vecMask) | ({27'h0, msiVectorNum} & vecMask);
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			intaAssert <= 1'b0;
			intaDeassert <= 1'b0;
		end else begin
			intaAssert <= legacySel && !msiEn && irqRise;
			intaDeassert <= legacySel && !msiEn && irqFall;
		end
	end
	// fatal error message and master poison filter
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			fatalErrMsg <= 1'b0;
			masterReqKeep <= 1'b0;
		end else begin
			fatalErrMsg <= endpoint && malformedTlp && ctrlReg[`BIEH_CTRL_ERREN];
			masterReqKeep <= masterReqValid && !(rootPort && masterReqPoison);
		end
	end

	// slave request tracking
	assign slaveReqReady = (state == BIEH_IDLE);
	assign reqTake = slaveReq.valid && slaveReqReady;
	// match against the outstanding id and tag
	assign cplMatch = (state == BIEH_WAIT) && (cplIn.reqId == ostId) && (cplIn.tag == ostTag);
	assign cplTimeout = (state == BIEH_WAIT) && (toCount >= toLimit) && !(cplIn.valid && cplMatch);

	// event strobes for the decode register
	always_comb begin
		next_set = 8'h00;
		next_set[`BIEH_IRQ_MSI] = rootPort && msiReceived; // root port only
		next_set[`BIEH_IRQ_MEP] = rootPort && masterReqValid && masterReqPoison;
		next_set[`BIEH_IRQ_SIB] = reqTake && (slaveReq.burst != `BIEH_BURST_INCR);
		next_set[`BIEH_IRQ_SUC] = cplIn.valid && !cplMatch;
		next_set[`BIEH_IRQ_SEP] = cplIn.valid && cplMatch && cplIn.poison;
		next_set[`BIEH_IRQ_SCA] = cplIn.valid && cplMatch && !cplIn.poison
			&& (cplIn.status == `BIEH_CPL_CA);
		next_set[`BIEH_IRQ_SUR] = cplIn.valid && cplMatch && !cplIn.poison
			&& (cplIn.status != `BIEH_CPL_CA) && (cplIn.status != `BIEH_CPL_SC);
		next_set[`BIEH_IRQ_SCT] = cplTimeout; // completion absent
	end
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			irqStrobe <= 8'h00;
		end else begin
			irqStrobe <= next_set;
		end
	end
	// non-posted incrementing-burst requests wait for their completion
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state <= BIEH_IDLE;
			ostId <= 16'h0000;
			ostTag <= 8'h00;
			toCount <= `BIEH_ZERO32;
		end else begin
			case (state)
				BIEH_IDLE: begin
					toCount <= `BIEH_ZERO32;
					if (reqTake && slaveReq.burst == `BIEH_BURST_INCR && !slaveReq.posted) begin
						state <= BIEH_WAIT;
						ostId <= slaveReq.reqId;
						ostTag <= slaveReq.tag;
					end
				end
				BIEH_WAIT: begin
					toCount <= toCount + 32'h0000_0001;
					// unmatched completions leave the wait untouched
					if ((cplIn.valid && cplMatch) || cplTimeout) begin
						state <= BIEH_IDLE;
					end
				end
				default: state <= BIEH_IDLE;
			endcase
		end
	end

	// answer to the slave bridge
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			slaveResp <= '0;
		end else begin
			slaveResp <= '0;
			if (reqTake && slaveReq.burst != `BIEH_BURST_INCR) begin
				slaveResp <= '{valid: 1'b1, isRead: slaveReq.isRead, resp: `BIEH_RESP_SLVERR};
			end else if (reqTake && slaveReq.posted) begin
				slaveResp <= '{valid: 1'b1, isRead: slaveReq.isRead, resp: `BIEH_RESP_OKAY};
			end else if (cplTimeout) begin
				slaveResp <= '{valid: 1'b1, isRead: 1'b1, resp: `BIEH_RESP_SLVERR};
			end else if (cplIn.valid && cplMatch) begin
				slaveResp.valid <= 1'b1;
				slaveResp.isRead <= 1'b1;
				slaveResp.resp <= (cplIn.poison || cplIn.status != `BIEH_CPL_SC)
					? `BIEH_RESP_SLVERR : `BIEH_RESP_OKAY;
			end
		end
	end

	// checks on the logic above
	a_local_irq_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
		((irqStrobe & maskReg) != 8'h00) |=> ##1 localIrq)
		else $error("unmasked event did not raise local interrupt");
	a_msi_recv_rp: assert property (@(posedge sys_clk) disable iff (!resetn)
		(msiReceived && !rootPort) |=> !irqStrobe[`BIEH_IRQ_MSI])
		else $error("message-received bit set outside root port mode");
	a_msi_rise_send: assert property (@(posedge sys_clk) disable iff (!resetn)
		(endpoint && msiEn && irqRequest && !irqPrev) |=> (msiOut.valid && msiOut.addr == $past(msiAddr)))
		else $error("MSI write missing after request edge");
	a_rp_ignores_req: assert property (@(posedge sys_clk) disable iff (!resetn)
		rootPort |=> !(msiOut.valid || intaAssert || intaDeassert))
		else $error("request honoured in root port mode");
	a_vector_clip: assert property (@(posedge sys_clk) disable iff (!resetn)
		(mme == 3'h0 && $stable(msiData)) |=> (!msiOut.valid || msiOut.data == $past(msiData)))
		else $error("vector bits leaked beyond allocation");
	a_inta_edges: assert property (@(posedge sys_clk) disable iff (!resetn)
		(legacySel && !msiEn && !irqRequest && irqPrev) |=> (intaDeassert && !intaAssert))
		else $error("deassert message missing after falling request");
	a_fatal_msg: assert property (@(posedge sys_clk) disable iff (!resetn)
		fatalErrMsg |-> $past(endpoint && malformedTlp && ctrlReg[`BIEH_CTRL_ERREN]))
		else $error("fatal message without enabled malformed event");
	a_bad_burst: assert property (@(posedge sys_clk) disable iff (!resetn)
		(reqTake && slaveReq.burst != `BIEH_BURST_INCR) |=>
		(slaveResp.valid && slaveResp.resp == `BIEH_RESP_SLVERR && irqStrobe[`BIEH_IRQ_SIB]))
		else $error("illegal burst not answered with error");
	a_unexp_cpl: assert property (@(posedge sys_clk) disable iff (!resetn)
		(cplIn.valid && !cplMatch && !cplTimeout && state == BIEH_WAIT) |=>
		(state == BIEH_WAIT && !slaveResp.valid))
		else $error("unexpected completion disturbed the request");
	a_abort_err: assert property (@(posedge sys_clk) disable iff (!resetn)
		(cplIn.valid && cplMatch && !cplIn.poison && cplIn.status == `BIEH_CPL_CA) |=>
		(irqStrobe[`BIEH_IRQ_SCA] && slaveResp.resp == `BIEH_RESP_SLVERR))
		else $error("completer abort not reported");
	a_timeout_err: assert property (@(posedge sys_clk) disable iff (!resetn)
		irqStrobe[`BIEH_IRQ_SCT] |-> ($past(state) == BIEH_WAIT && slaveResp.valid && state == BIEH_IDLE))
		else $error("timeout strobe without waiting request");
	a_sticky_set: assert property (@(posedge sys_clk) disable iff (!resetn)
		(irqStrobe != 8'h00) |=> ((decode & $past(irqStrobe)) == $past(irqStrobe)))
		else $error("strobe did not set its decode bit");
endmodule : bieh_top

// ### bench/bieh_link_model.sv
/*
 * Far-side link model: answers each non-posted incrementing slave request
 * with one completion, good or faulty as cplMode selects; none in mode 6.
 * Assumes it shares sys_clk and resetn with the bridge block.
 */
`timescale 1ns/1ps
`include "bieh_consts.svh"
module bieh_link_model (
	input wire logic sys_clk, // bridge clock
	input wire logic resetn, // synchronous reset, active low
	input wire bieh_pkg::bieh_sreq_t slaveReq, // request seen on the link
	input wire logic slaveReqReady, // request taken when high
	input wire logic [2:0] cplMode, // 0 ok,1 ur,2 rsvd,3 ca,4 poison,5 tag,6 none
	output bieh_pkg::bieh_cpl_t cplIn // completion towards the bridge
);
	import bieh_pkg::*;
	bieh_sreq_t held;
	int dly;
	// completion after three cycles; idle fields toggle so stale values never match
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			dly <= 0;
			cplIn <= '0;
		end else begin
			cplIn.valid <= 1'b0;
			cplIn.tag <= ~cplIn.tag;
			cplIn.reqId <= ~cplIn.reqId;
			if (slaveReq.valid && slaveReqReady && !slaveReq.posted
				&& slaveReq.burst == `BIEH_BURST_INCR) begin
				held <= slaveReq;
				dly <= 3;
			end else if (dly == 1) begin
				dly <= 0;
				if (cplMode != 3'h6) begin
					cplIn.valid <= 1'b1;
					cplIn.reqId <= held.reqId;
					cplIn.tag <= held.tag ^ ((cplMode == 3'h5) ? 8'hFF : 8'h00);
					cplIn.status <= (cplMode == 3'h1) ? 3'h1 : (cplMode == 3'h2) ? 3'h3 :
						(cplMode == 3'h3) ? `BIEH_CPL_CA : `BIEH_CPL_SC;
					cplIn.poison <= (cplMode == 3'h4);
				end
			end else if (dly > 1) begin
				dly <= dly - 1;
			end
		end
	end
endmodule : bieh_link_model

// ### bench/testbench.sv
/*
 * Self-checking bench for the bridge interrupt and error block.
 * Assumes bieh_pkg and bieh_consts.svh are compiled and on the include path.
 */
`timescale 1ns/1ps
`include "bieh_consts.svh"
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin errors++; \
	$display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module testbench;
	import bieh_pkg::*;
	logic sys_clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, msiDat, msiAdr, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, lastResp, rr;
	logic irqRequest, msiReceived, malformedTlp, masterReqValid, masterReqPoison;
	logic slaveReqReady, intaAssert, intaDeassert, fatalErrMsg, masterReqKeep, localIrq;
	logic msiEnable, lastRd;
	logic [4:0] msiVectorNum;
	logic [2:0] msiVectorWidth, cplMode;
	bieh_sreq_t slaveReq;
	bieh_cpl_t cplIn;
	bieh_sresp_t slaveResp;
	bieh_msi_t msiOut;
	bieh_irqvec_t irqStrobe;
	int errors, cmp_count;
	int cnt[14], base[14];
	bieh_top dut_u (.sys_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irqRequest, .msiVectorNum, .msiReceived,
		.malformedTlp, .masterReqValid, .masterReqPoison, .slaveReq, .slaveReqReady, .cplIn,
		.slaveResp, .msiOut, .intaAssert, .intaDeassert, .fatalErrMsg, .masterReqKeep,
		.irqStrobe, .localIrq, .msiEnable, .msiVectorWidth);
	bieh_link_model link_u (.sys_clk, .resetn, .slaveReq, .slaveReqReady, .cplMode, .cplIn);
	// clock
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// event counters for one-cycle outputs
	always @(posedge sys_clk) begin
		for (int i = 0; i < 8; i++) cnt[i] += irqStrobe[i];
		cnt[8] += msiOut.valid;
		cnt[9] += intaAssert;
		cnt[10] += intaDeassert;
		cnt[11] += fatalErrMsg;
		cnt[12] += masterReqKeep;
		cnt[13] += slaveResp.valid;
		if (msiOut.valid) begin
			msiDat = msiOut.data;
			msiAdr = msiOut.addr;
		end
		if (slaveResp.valid) {lastRd, lastResp} = {slaveResp.isRead, slaveResp.resp};
	end
	function automatic int dlt(input int i);
		return cnt[i] - base[i];
	endfunction : dlt
	task step(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : step
	task awr(input logic [7:0] a, input logic [31:0] d);
		int n;
		begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			n = 0;
			@(posedge sys_clk);
			while (s_axi_awready !== 1'b1 && n < 50) begin n++; @(posedge sys_clk); end
			s_axi_awvalid <= 1'b0;
			s_axi_wvalid <= 1'b0;
			@(posedge sys_clk);
			while (s_axi_bvalid !== 1'b1 && n < 50) begin n++; @(posedge sys_clk); end
			rr = s_axi_bresp;
			`CHK("awr limit", 1'b1, n < 50)
		end
	endtask : awr
	task ard(input logic [7:0] a);
		int n;
		begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			n = 0;
			@(posedge sys_clk);
			while (s_axi_arready !== 1'b1 && n < 50) begin n++; @(posedge sys_clk); end
			s_axi_arvalid <= 1'b0;
			@(posedge sys_clk);
			while (s_axi_rvalid !== 1'b1 && n < 50) begin n++; @(posedge sys_clk); end
			rr = s_axi_rresp;
			rd = s_axi_rdata;
			`CHK("ard limit", 1'b1, n < 50)
		end
	endtask : ard
	// pulse on {msiReceived, malformedTlp, masterReqValid, masterReqPoison}
	task pls(input logic [3:0] w);
		base = cnt;
		{msiReceived, malformedTlp, masterReqValid, masterReqPoison} <= w;
		step(1);
		{msiReceived, malformedTlp, masterReqValid, masterReqPoison} <= 4'h0;
		step(4);
	endtask : pls
	task edges(input logic [4:0] v);
		base = cnt;
		msiVectorNum <= v;
		irqRequest <= 1'b1;
		step(4);
		irqRequest <= 1'b0;
		step(4);
	endtask : edges
	task slv(input logic [1:0] bst, input logic pst, input logic isr, input logic [2:0] md,
		input logic [1:0] er, input bieh_irqvec_t es);
		int n;
		bieh_irqvec_t got;
		begin
			base = cnt;
			cplMode <= md;
			slaveReq <= '{1'b1, isr, pst, bst, 16'h0100, 8'h2A};
			n = 0;
			@(posedge sys_clk);
			while (slaveReqReady !== 1'b1 && n < 50) begin n++; @(posedge sys_clk); end
			slaveReq <= '{1'b0, ~isr, ~pst, ~bst, 16'hFEFF, 8'hD5};
			while (dlt(13) == 0 && n < 90) begin n++; @(negedge sys_clk); end
			step(2);
			for (int i = 0; i < 8; i++) got[i] = (dlt(i) != 0);
			`CHK("slave limit", 1'b1, n < 90)
			`CHK("slave resp", er, lastResp)
			`CHK("slave isrd", isr, lastRd)
			`CHK("slave strobes", es, got)
		end
	endtask : slv
	task summarize;
		$display("checks %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize
	task t_regs;
		ard(`BIEH_OFF_MSICTL);
		`CHK("msictl cap", 32'h0000_000A, rd & 32'h0000_000F)
		ard(`BIEH_OFF_TIMEOUT);
		`CHK("timeout rst", `BIEH_TIMEOUT_RST, rd)
		ard(8'h40);
		`CHK("unmapped rd", `BIEH_RESP_SLVERR, rr)
		awr(8'h40, 32'h0000_0001);
		`CHK("unmapped wr", `BIEH_RESP_SLVERR, rr)
		awr(`BIEH_OFF_TIMEOUT, 32'h0000_0014);
		$display("test regs done");
	endtask : t_regs
	task t_msi;
		logic [31:0] m;
		int mm[3] = '{0, 2, 5};
		awr(`BIEH_OFF_CTRL, 32'h0000_0012);
		awr(`BIEH_OFF_MSIADDR, 32'hFEE0_1000);
		awr(`BIEH_OFF_MSIDATA, 32'h0000_4567);
		foreach (mm[i]) begin
			awr(`BIEH_OFF_MSICTL, 32'h0000_0001 | (32'(mm[i]) << 4));
			// one vector per request, bench orders them
			edges(5'h1E);
			m = (32'h0000_0001 << mm[i]) - 32'h0000_0001;
			`CHK("msi count", 1, dlt(8))
			`CHK("msi addr", 32'hFEE0_1000, msiAdr)
			`CHK("msi data", (32'h0000_4567 & ~m) | (32'h0000_001E & m), msiDat)
			`CHK("vec width", 3'(mm[i]), msiVectorWidth)
			`CHK("msi en", 1'b1, msiEnable)
			`CHK("no inta", 0, dlt(9))
		end
		$display("test msi done");
	endtask : t_msi
	task t_modes;
		awr(`BIEH_OFF_MSICTL, 32'h0000_0000);
		`CHK("msi en off", 1'b0, msiEnable)
		edges(5'h00);
		`CHK("inta assert", 1, dlt(9))
		`CHK("inta deassert", 1, dlt(10))
		awr(`BIEH_OFF_CTRL, 32'h0000_0010);
		edges(5'h00);
		`CHK("no pin inta", 0, dlt(9) + dlt(10))
		awr(`BIEH_OFF_MSICTL, 32'h0000_0001);
		awr(`BIEH_OFF_CTRL, 32'h0000_0001);
		edges(5'h03);
		`CHK("root ignores req", 0, dlt(8) + dlt(9))
		pls(4'h8);
		`CHK("root msi rx", 1, dlt(0))
		pls(4'h3);
		`CHK("poison strobe", 1, dlt(7))
		`CHK("poison dropped", 0, dlt(12))
		pls(4'h2);
		`CHK("clean kept", 1, dlt(12))
		awr(`BIEH_OFF_CTRL, 32'h0000_0012);
		pls(4'h8);
		`CHK("ep msi rx", 0, dlt(0))
		pls(4'h4);
		`CHK("fatal sent", 1, dlt(11))
		awr(`BIEH_OFF_CTRL, 32'h0000_0002);
		pls(4'h4);
		`CHK("fatal off", 0, dlt(11))
		$display("test modes done");
	endtask : t_modes
	task t_slave;
		bieh_irqvec_t ex[7] = '{8'h00, 8'h08, 8'h08, 8'h40, 8'h20, 8'h14, 8'h10};
		slv(2'h0, 1'b0, 1'b1, 3'h0, `BIEH_RESP_SLVERR, 8'h02);
		slv(2'h2, 1'b0, 1'b0, 3'h0, `BIEH_RESP_SLVERR, 8'h02);
		slv(`BIEH_BURST_INCR, 1'b1, 1'b0, 3'h0, `BIEH_RESP_OKAY, 8'h00);
		for (int i = 0; i < 7; i++)
			slv(`BIEH_BURST_INCR, 1'b0, 1'b1, 3'(i), (i == 0) ? `BIEH_RESP_OKAY :
				`BIEH_RESP_SLVERR, ex[i]);
		$display("test slave done");
	endtask : t_slave
	task t_irq;
		awr(`BIEH_OFF_DECODE, 32'h0000_00FF);
		awr(`BIEH_OFF_MASK, 32'h0000_0000);
		slv(`BIEH_BURST_INCR, 1'b0, 1'b1, 3'h6, `BIEH_RESP_SLVERR, 8'h10);
		ard(`BIEH_OFF_DECODE);
		`CHK("decode sticky", 32'h0000_0010, rd & 32'h0000_00FF)
		`CHK("masked irq", 1'b0, localIrq)
		awr(`BIEH_OFF_MASK, 32'h0000_0010);
		step(3);
		`CHK("unmasked irq", 1'b1, localIrq)
		awr(`BIEH_OFF_DECODE, 32'h0000_0010);
		step(3);
		ard(`BIEH_OFF_DECODE);
		`CHK("decode clr", 32'h0000_0000, rd & 32'h0000_00FF)
		`CHK("irq clr", 1'b0, localIrq)
		$display("test irq done");
	endtask : t_irq
	// time-zero values, reset, tests
	initial begin
		resetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, irqRequest} = 4'h0;
		{msiReceived, malformedTlp, masterReqValid, masterReqPoison} = 4'h0;
		{s_axi_bready, s_axi_rready} = 2'h3;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hF;
		msiVectorNum = 5'h00;
		slaveReq = '0;
		cplMode = 3'h0;
		step(8);
		resetn <= 1'b1;
		step(1);
		t_regs();
		t_msi();
		t_modes();
		t_slave();
		t_irq();
		summarize();
	end
	// watchdog
	initial begin
		#160000;
		errors++;
		summarize();
	end
endmodule : testbench
